/* File: logic/acrp_port.sv */
// Request and answer port that writes and reads back per-lane analog settings.
`timescale 1ns/1ps

module acrp_port (
  input  wire logic                             CLOCK_IN,
  input  wire logic                             RST_N_IN,
  input  wire acrp_pkg::acrp_req_s              REQ_IN,
  input  wire acrp_pkg::acrp_lane_cfg_s         LANE_CFG_IN,
  input  wire acrp_pkg::acrp_cfg_e              CFG_KIND_IN,
  output logic                                  BUSY_OUT,
  output logic                                  RD_VALID_OUT,
  output logic [acrp_pkg::PACKED_W-1:0]         SWING_RB_OUT,
  output logic [acrp_pkg::SWING_W-1:0]          SWING_SEL_OUT,
  output logic                                  CFG_ALLOWED_OUT
);

  // ****************************************
  // Transaction sequencer
  // ****************************************
  typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_READ} acrp_state_e;

  acrp_state_e                   state_r, state_nxt;
  logic [3:0]                    cnt_r, cnt_nxt;
  acrp_pkg::acrp_req_s           held_r;
  logic [acrp_pkg::NUM_LANES-1:0] lane_wr;
  logic [acrp_pkg::PACKED_W-1:0] tx_all, rx_all;
  logic [acrp_pkg::PACKED_W-1:0] rb_nxt;
  logic                          rd_done;
  logic                          wr_done;

  // Strobes are only looked at in idle, so a running transaction is never disturbed.
  wire take_wr = (state_r == ST_IDLE) && REQ_IN.write && !REQ_IN.read;
  wire take_rd = (state_r == ST_IDLE) && REQ_IN.read && !REQ_IN.write;
  wire last    = (cnt_r == acrp_pkg::ACCESS_CYC - 4'h1);

  assign wr_done = (state_r == ST_WRITE) && last;
  assign rd_done = (state_r == ST_READ) && last;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      ST_IDLE: begin
        cnt_nxt = 4'h0;
        if (take_wr) begin
          state_nxt = ST_WRITE;
        end else if (take_rd) begin
          state_nxt = ST_READ;
        end
      end
      ST_WRITE, ST_READ: begin
        cnt_nxt = cnt_r + 4'h1;
        if (last) begin
          state_nxt = ST_IDLE;
          cnt_nxt   = 4'h0;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      state_r <= ST_IDLE;
      cnt_r   <= 4'h0;
      held_r  <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      if (take_wr || take_rd) begin
        held_r <= REQ_IN;
      end
    end
  end

  // Busy comes straight from the state, so it falls in the cycle valid rises.
  assign BUSY_OUT = (state_r != ST_IDLE);

  // ****************************************
  // Lane stores
  // ****************************************
  for (genvar i = 0; i < acrp_pkg::NUM_LANES; i++) begin : g_lane
    logic [acrp_pkg::SWING_W-1:0] wval;
    // Shared mode uses the low field for all lanes; per-lane uses each lane's field.
    assign wval = (held_r.mode == acrp_pkg::MODE_PER_LANE) ?
                  held_r.swing[i*acrp_pkg::SWING_W +: acrp_pkg::SWING_W] :
                  held_r.swing[acrp_pkg::SWING_W-1:0];
    assign lane_wr[i] = wr_done &&
                        ((held_r.mode != acrp_pkg::MODE_LANE_INDEX) ||
                         (held_r.lane == acrp_pkg::LANE_IDX_W'(i)));
    acrp_lane u_lane (
      .CLOCK_IN     (CLOCK_IN),
      .RST_N_IN     (RST_N_IN),
      .WR_IN        (lane_wr[i]),
      .DIR_IN       (held_r.dir),
      .SWING_IN     (wval),
      .TX_SWING_OUT (tx_all[i*acrp_pkg::SWING_W +: acrp_pkg::SWING_W]),
      .RX_SWING_OUT (rx_all[i*acrp_pkg::SWING_W +: acrp_pkg::SWING_W])
    );
  end

  // ****************************************
  // Readback
  // ****************************************
  // A receiver-only read returns receiver values; any other direction the transmitter's.
  assign rb_nxt = (held_r.dir == acrp_pkg::DIR_RX_ONLY) ? rx_all : tx_all;

  wire [acrp_pkg::SWING_W-1:0] sel_nxt =
    rb_nxt[held_r.lane*acrp_pkg::SWING_W +: acrp_pkg::SWING_W];

  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      SWING_RB_OUT  <= '0;
      SWING_SEL_OUT <= '0;
      RD_VALID_OUT  <= 1'b0;
    end else begin
      RD_VALID_OUT <= rd_done;
      if (rd_done) begin
        SWING_RB_OUT  <= rb_nxt;
        SWING_SEL_OUT <= sel_nxt;
      end
    end
  end

  // ****************************************
  // Reconfiguration legality
  // ****************************************
  // Only the device-side limits are judged; mode moves the requester must avoid are not seen here.
  wire bond_ok = LANE_CFG_IN.bonded &&
                 ((LANE_CFG_IN.bond_width == 4'h4) || (LANE_CFG_IN.bond_width == 4'h8));
  wire div_ok  = !LANE_CFG_IN.bonded && LANE_CFG_IN.tx_only;
  wire pll_ok  = !LANE_CFG_IN.bonded || LANE_CFG_IN.direct_analog;

  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      CFG_ALLOWED_OUT <= 1'b0;
    end else begin
      case (CFG_KIND_IN)
        acrp_pkg::CFG_DATA_RATE_DIV: CFG_ALLOWED_OUT <= div_ok;
        acrp_pkg::CFG_CENTRAL_UNIT:  CFG_ALLOWED_OUT <= bond_ok;
        acrp_pkg::CFG_PLL_SELECT:    CFG_ALLOWED_OUT <= pll_ok;
        default:                     CFG_ALLOWED_OUT <= 1'b1;
      endcase
    end
  end

endmodule // acrp_port

/* File: include/acrp_pkg.sv */
// Package of constants and carrier types for the analog control reconfiguration port.
package acrp_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int NUM_LANES  = 4;
  localparam int LANE_IDX_W = 2;
  localparam int SWING_W    = 3;
  localparam int PACKED_W   = NUM_LANES * SWING_W;

  // ****************************************
  // Timing and reset values
  // ****************************************
  localparam int ACCESS_NS  = 40;
  localparam int CLK_NS     = 10;
  localparam logic [3:0] ACCESS_CYC = 4'((ACCESS_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [SWING_W-1:0] SWING_RST = 3'h0;

  // ****************************************
  // Encodings
  // ****************************************
  localparam logic [1:0] DIR_IDLE    = 2'h0;
  localparam logic [1:0] DIR_RX_ONLY = 2'h1;
  localparam logic [1:0] DIR_TX_ONLY = 2'h2;
  localparam logic [1:0] DIR_DUPLEX  = 2'h3;

  typedef enum logic [1:0] {
    MODE_LANE_INDEX,
    MODE_SHARED,
    MODE_PER_LANE
  } acrp_mode_e;

  typedef enum logic [1:0] {
    CFG_DATA_RATE_DIV,
    CFG_CENTRAL_UNIT,
    CFG_PLL_SELECT,
    CFG_OTHER
  } acrp_cfg_e;

  typedef struct packed {
    logic                    write;
    logic                    read;
    acrp_mode_e              mode;
    logic [1:0]              dir;
    logic [LANE_IDX_W-1:0]   lane;
    logic [PACKED_W-1:0]     swing;
  } acrp_req_s;

  typedef struct packed {
    logic          bonded;
    logic [3:0]    bond_width;
    logic          tx_only;
    logic          direct_analog;
  } acrp_lane_cfg_s;

endpackage

/* File: logic/acrp_lane.sv */
// One lane's analog front end swing store for transmitter and receiver parts.
`timescale 1ns/1ps
module acrp_lane (
  input  wire logic                          CLOCK_IN,
  input  wire logic                          RST_N_IN,
  input  wire logic                          WR_IN,
  input  wire logic [1:0]                    DIR_IN,
  input  wire logic [acrp_pkg::SWING_W-1:0]  SWING_IN,
  output logic      [acrp_pkg::SWING_W-1:0]  TX_SWING_OUT,
  output logic      [acrp_pkg::SWING_W-1:0]  RX_SWING_OUT
);

  // Transmitter-only writes leave the receiver value alone.
  wire wr_tx = WR_IN && (DIR_IN != acrp_pkg::DIR_RX_ONLY);
  wire wr_rx = WR_IN && (DIR_IN != acrp_pkg::DIR_TX_ONLY);

  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      TX_SWING_OUT <= acrp_pkg::SWING_RST;
      RX_SWING_OUT <= acrp_pkg::SWING_RST;
    end else begin
      if (wr_tx) begin
        TX_SWING_OUT <= SWING_IN;
      end
      if (wr_rx) begin
        RX_SWING_OUT <= SWING_IN;
      end
    end
  end

endmodule // acrp_lane

/* File: tb/acrp_port_monitor.sv */
// Checker of the request port timing and legality outputs.
`timescale 1ns/1ps
module acrp_port_monitor (
  input wire logic                          CLOCK_IN,
  input wire logic                          RST_N_IN,
  input wire acrp_pkg::acrp_req_s           REQ_IN,
  input wire acrp_pkg::acrp_lane_cfg_s      LANE_CFG_IN,
  input wire acrp_pkg::acrp_cfg_e           CFG_KIND_IN,
  input wire logic                          BUSY_OUT,
  input wire logic                          RD_VALID_OUT,
  input wire logic [acrp_pkg::PACKED_W-1:0] SWING_RB_OUT,
  input wire logic                          CFG_ALLOWED_OUT
);
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (!RST_N_IN);
  busy_len_a: assert property (
    !BUSY_OUT && (REQ_IN.write ^ REQ_IN.read) |=> BUSY_OUT [*4] ##1 !BUSY_OUT)
    else $error("busy window wrong");
  read_answer_a: assert property (
    !BUSY_OUT && REQ_IN.read && !REQ_IN.write |=> ##4 RD_VALID_OUT)
    else $error("read answer missing");
  valid_pulse_a: assert property (RD_VALID_OUT |=> !RD_VALID_OUT)
    else $error("valid longer than one cycle");
  valid_idle_a: assert property (RD_VALID_OUT |-> !BUSY_OUT && $past(BUSY_OUT))
    else $error("valid outside busy end");
  both_ignored_a: assert property (
    !BUSY_OUT && REQ_IN.write && REQ_IN.read |=> !BUSY_OUT)
    else $error("joint strobes taken");
  rb_hold_a: assert property (!RD_VALID_OUT |-> $stable(SWING_RB_OUT))
    else $error("readback moved without read");
  cu_ok_a: assert property (
    CFG_KIND_IN == acrp_pkg::CFG_CENTRAL_UNIT && LANE_CFG_IN.bonded
    && LANE_CFG_IN.bond_width inside {4'h4, 4'h8} |=> CFG_ALLOWED_OUT)
    else $error("central unit refused");
  div_bad_a: assert property (
    CFG_KIND_IN == acrp_pkg::CFG_DATA_RATE_DIV
    && (LANE_CFG_IN.bonded || !LANE_CFG_IN.tx_only) |=> !CFG_ALLOWED_OUT)
    else $error("rate division allowed");
  pll_bad_a: assert property (
    CFG_KIND_IN == acrp_pkg::CFG_PLL_SELECT && LANE_CFG_IN.bonded
    && !LANE_CFG_IN.direct_analog |=> !CFG_ALLOWED_OUT)
    else $error("pll select allowed");
endmodule // acrp_port_monitor
bind acrp_port acrp_port_monitor u_acrp_port_monitor (.CLOCK_IN, .RST_N_IN, .REQ_IN,
  .LANE_CFG_IN, .CFG_KIND_IN, .BUSY_OUT, .RD_VALID_OUT, .SWING_RB_OUT, .CFG_ALLOWED_OUT);

/* File: tb/acrp_requester.sv */
// Model of the user logic that issues write and read requests.
`timescale 1ns/1ps
module acrp_requester (
  input  wire logic                          clk_in,
  input  wire logic                          busy_in,
  input  wire logic                          valid_in,
  input  wire logic [acrp_pkg::PACKED_W-1:0] rb_in,
  output acrp_pkg::acrp_req_s                req_out
);
  initial req_out = '0;
  // Only analog settings are ever requested, never a functional or bonding mode move.
  // The strobe is only raised once busy is seen low, so nothing is lost.
  task automatic xfer(input logic w, input logic r, input acrp_pkg::acrp_mode_e m,
                      input logic [1:0] d, input logic [1:0] l,
                      input logic [11:0] s, output logic [11:0] q);
    q = 'x;
    do @(negedge clk_in); while (busy_in);
    @(posedge clk_in);
    req_out <= '{write: w, read: r, mode: m, dir: d, lane: l, swing: s};
    @(posedge clk_in);
    req_out.write <= 1'b0;
    req_out.read  <= 1'b0;
    req_out.swing <= ~s; // Released data must not keep looking valid.
    repeat (8) begin
      @(negedge clk_in);
      if (valid_in === 1'b1) q = rb_in;
    end
  endtask
  // A second write strobe is raised while busy is high, so the block must drop it.
  task automatic intrude(input logic [11:0] s1, input logic [11:0] s2);
    do @(negedge clk_in); while (busy_in);
    @(posedge clk_in);
    req_out <= '{write: 1'b1, read: 1'b0, mode: acrp_pkg::MODE_SHARED, dir: 2'h2, lane: 2'h0,
                 swing: s1};
    @(posedge clk_in);
    req_out.write <= 1'b0;
    @(posedge clk_in);
    req_out.write <= 1'b1;
    req_out.swing <= s2;
    @(posedge clk_in);
    req_out.write <= 1'b0;
    repeat (8) @(negedge clk_in);
  endtask
endmodule // acrp_requester

/* File: tb/tb.sv */
// Self-checking bench for the analog control reconfiguration port.
`timescale 1ns/1ps
module tb;
  logic                     clk = 1'b0;
  logic                     rst_n = 1'b0;
  acrp_pkg::acrp_req_s      req;
  acrp_pkg::acrp_lane_cfg_s lcfg = '0;
  acrp_pkg::acrp_cfg_e      kind = acrp_pkg::CFG_OTHER;
  logic                     busy, valid, allowed;
  logic [11:0]              rb, q;
  logic [2:0]               sel;
  int                       n_mismatch = 0, num_checks = 0, cyc = 0;
  logic [9:0]               tbl [11] = '{10'h1a1, 10'h1c1, 10'h120, 10'h190, 10'h005,
                                         10'h084, 10'h000, 10'h201, 10'h2a0, 10'h2a3, 10'h3a1};
  always #5 clk = ~clk;
  acrp_port u_acrp_port (.CLOCK_IN(clk), .RST_N_IN(rst_n), .REQ_IN(req), .LANE_CFG_IN(lcfg),
    .CFG_KIND_IN(kind), .BUSY_OUT(busy), .RD_VALID_OUT(valid), .SWING_RB_OUT(rb),
    .SWING_SEL_OUT(sel), .CFG_ALLOWED_OUT(allowed));
  acrp_requester u_acrp_requester (.clk_in(clk), .busy_in(busy), .valid_in(valid),
    .rb_in(rb), .req_out(req));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(input acrp_pkg::acrp_mode_e m, input logic [1:0] d, input logic [1:0] l,
                    input logic [11:0] s);
    u_acrp_requester.xfer(1'b1, 1'b0, m, d, l, s, q);
  endtask
  task automatic rd(input logic [1:0] d);
    u_acrp_requester.xfer(1'b0, 1'b1, acrp_pkg::MODE_LANE_INDEX, d, 2'h2, 12'h0, q);
  endtask
  // A hang is cut short well above the two hundred or so cycles the tests need.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      conclude();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk({busy, valid, rb}, 16'h0);
    for (int i = 0; i < 4; i++) wr(acrp_pkg::MODE_LANE_INDEX, 2'h2, 2'(i), 12'(i + 1));
    rd(2'h2);
    chk(q, 16'h8d1);
    chk(sel, 16'h3);
    wr(acrp_pkg::MODE_LANE_INDEX, 2'h1, 2'h1, 12'h7);
    rd(2'h1);
    chk(q, 16'h38);
    rd(2'h2);
    chk(q, 16'h8d1);
    $display("lane index test done");
    wr(acrp_pkg::MODE_SHARED, 2'h0, 2'h0, 12'hff5);
    rd(2'h1);
    chk(q, 16'hb6d);
    rd(2'h2);
    chk(q, 16'hb6d);
    wr(acrp_pkg::MODE_PER_LANE, 2'h2, 2'h0, (q & 12'hfc7) | 12'h010);
    u_acrp_requester.xfer(1'b1, 1'b1, acrp_pkg::MODE_SHARED, 2'h0, 2'h0, 12'h0, q);
    rd(2'h2);
    chk(q, 16'hb55);
    $display("shared and per lane tests done");
    u_acrp_requester.intrude(12'h003, 12'h006);
    rd(2'h3);
    chk(q, 16'h6db);
    rd(2'h1);
    chk(q, 16'hb6d);
    $display("busy refusal test done");
    foreach (tbl[i]) begin
      @(posedge clk);
      kind <= acrp_pkg::acrp_cfg_e'(tbl[i][9:8]);
      lcfg <= '{bonded: tbl[i][7], bond_width: tbl[i][6:3], tx_only: tbl[i][2],
                direct_analog: tbl[i][1]};
      repeat (2) @(negedge clk);
      chk(allowed, tbl[i][0]);
    end
    $display("legality test done");
    conclude();
  end
endmodule // tb
